// file: logic/lpss_pkg.sv
/*
 Shared constants of the linear pixel scan sequencer: array size, setup
 clock count, pixel clock divider, charge transfer and frame period limits.
 Assumes a single system clock of 250 MHz for both ends.
*/
package lpss_pkg;

   // ----------------------------------------------------------------
   // Array and data widths
   // ----------------------------------------------------------------
   localparam int          PIXEL_COUNT = 768;
   localparam int          IDX_W       = 10;
   localparam int          LEVEL_W     = 12;
   localparam logic [9:0]  PIXELS      = 10'h300;
   localparam logic [9:0]  SETUP_CLKS  = 10'h012;
   localparam logic [11:0] LEVEL_MAX   = 12'hFFF;
   localparam logic [11:0] LEVEL_RESET = 12'h000;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_KHZ        = 250000;
   localparam int CLK_PERIOD_PS  = 4000;
   localparam int PIX_CLK_MAX_KHZ = 8000;
   // Least half period, rounded up so the pixel clock never exceeds max
   localparam int HALF_CYCLES_I  =
      (CLK_KHZ + 2 * PIX_CLK_MAX_KHZ - 1) / (2 * PIX_CLK_MAX_KHZ);
   localparam logic [4:0] HALF_CYCLES = 5'(HALF_CYCLES_I);
   localparam int CHARGE_XFER_US = 20;
   // Least time, rounded up
   localparam int XFER_CYCLES_I  =
      (CHARGE_XFER_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int MAX_PERIOD_MS  = 100;
   // Longest time, rounded down
   localparam int MAX_PERIOD_I   =
      int'((64'(MAX_PERIOD_MS) * 64'd1000000000) / 64'(CLK_PERIOD_PS));

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [9:0] COUNT_RESET = 10'h000;
   localparam logic [4:0] PHASE_RESET = 5'h00;

endpackage : lpss_pkg

// file: logic/lpss_link_if.sv
/*
 Link between the host sequencer and the sensor section: pixel clock,
 scan start, data latch and the sampled pixel output with its enable.
 Assumes both ends run on the same system clock; the output enable stands
 for the high-impedance state of the pixel output.
*/
`timescale 1ns/1ps
interface lpss_link_if;
   logic        pixel_clk;
   logic        scan_start;
   logic        data_latch;
   logic [11:0] analog_pixel_out;
   logic        analog_pixel_out_oe;

   modport sensor (
      input  pixel_clk,
      input  scan_start,
      input  data_latch,
      output analog_pixel_out,
      output analog_pixel_out_oe
   );

   modport host (
      output pixel_clk,
      output scan_start,
      output data_latch,
      input  analog_pixel_out,
      input  analog_pixel_out_oe
   );
endinterface : lpss_link_if

// file: logic/lpss_sensor.sv
/*
 Sensor end of the linear pixel scan sequencer: per-pixel integrators,
 a hold stage, the setup/readout counter and the pixel output.
 Assumes pixel_clk, scan_start and data_latch are synchronous to clk and
 that the pixel clock high and low phases last at least two clk cycles.
*/

// Behaviour
// - Host drops scan start before next rising clock.
// - Host gives n+1 clocks between scan starts.
// - Host adds 20 us transfer wait afterwards.
// - Scan start and data latch share one signal.
// - Integration equals start-to-latch minus 18 clocks.
// - Scan start captures all pixels, presents first.
// - Each clock advances output by one pixel.
// - Integrators reset for scan clock plus 17.
// - Integrators released together on 19th clock.
// - First 18 pixels track again at 19th.
// - Later pixels track the clock after readout.
// - Clock n+1 tracks last pixel, floats output.
// - Host keeps scan period within 100 ms; the host only flags period_overrun.
// - Host keeps integration above minimum time.
// - Readout of old data overlaps new integration.
// - Host discards first scan after power-up.
// - Host parks pixel clock low when idle.
// - Host pixel clock at most 8 MHz.
// - Each pixel value stable whole clock period.
`timescale 1ns/1ps
module lpss_sensor (
   input  wire logic                   clk,
   input  wire logic                   reset_n,
   lpss_link_if.sensor                 lnk,
   input  wire logic                   light_valid,
   input  wire logic [9:0]             light_index,
   input  wire logic [11:0]            light_level,
   output logic                        integrator_reset_switch,
   output logic [9:0]                  sample_select_switch,
   output logic [9:0]                  readout_index,
   output logic                        readout_active
);

   // ----------------------------------------------------------------
   // Types and storage
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      LPSS_IDLE  = 3'b001,
      LPSS_SETUP = 3'b010,
      LPSS_READ  = 3'b100
   } lpss_phase_type;

   lpss_phase_type phase;
   logic           pclk_q;
   logic           rise;
   logic           scan_hit;
   logic [9:0]     count;
   logic [9:0]     next_count;
   logic [11:0]    integ [lpss_pkg::PIXEL_COUNT];
   logic [11:0]    held  [lpss_pkg::PIXEL_COUNT];

   // Saturating add: a bright pixel clips at full scale, never wraps
   function automatic logic [11:0] lpss_sat_add(
      input logic [11:0] a,
      input logic [11:0] b
   );
      logic [12:0] sum;
      sum = {1'b0, a} + {1'b0, b};
      if (sum[12]) begin
         return lpss_pkg::LEVEL_MAX;
      end
      return sum[11:0];
   endfunction : lpss_sat_add

   // ----------------------------------------------------------------
   // Pixel clock edge detection
   // ----------------------------------------------------------------
   // Resets low like the parked pixel clock, so no false rise follows
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         pclk_q <= 1'b0;
      end else begin
         pclk_q <= lnk.pixel_clk;
      end
   end

   assign rise       = lnk.pixel_clk & ~pclk_q;
   assign scan_hit   = rise & lnk.scan_start;
   assign next_count = count + 10'h001;

   // ----------------------------------------------------------------
   // Scan counter: clock edges since the scan start edge
   // ----------------------------------------------------------------
   // A scan start in mid-readout restarts the count from zero
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         phase <= LPSS_IDLE;
         count <= lpss_pkg::COUNT_RESET;
      end else if (scan_hit) begin
         phase <= LPSS_SETUP;
         count <= lpss_pkg::COUNT_RESET;
      end else if (rise) begin
         case (phase)
            LPSS_SETUP: begin
               count <= next_count;
               if (next_count == lpss_pkg::SETUP_CLKS) begin
                  phase <= LPSS_READ;
               end
            end
            LPSS_READ: begin
               count <= next_count;
               if (next_count == lpss_pkg::PIXELS) begin
                  phase <= LPSS_IDLE;
               end
            end
            default: begin
               phase <= LPSS_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Integrator reset switch
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         integrator_reset_switch <= 1'b0;
      end else if (scan_hit) begin
         integrator_reset_switch <= 1'b1;
      end else if (rise && phase == LPSS_SETUP &&
                   next_count == lpss_pkg::SETUP_CLKS) begin
         integrator_reset_switch <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Integrators: accumulate light unless held in reset
   // ----------------------------------------------------------------
   // Scan start clears at once; the switch then holds zero until release
   always_ff @(posedge clk) begin
      for (int i = 0; i < lpss_pkg::PIXEL_COUNT; i++) begin
         if (!reset_n || integrator_reset_switch || scan_hit) begin
            integ[i] <= lpss_pkg::LEVEL_RESET;
         end else if (light_valid && light_index == 10'(i)) begin
            integ[i] <= lpss_sat_add(integ[i], light_level);
         end
      end
   end

   // ----------------------------------------------------------------
   // Hold stage: all pixels captured at once on the latch edge
   // ----------------------------------------------------------------
   // Old frame is read out while the integrators gather the next one
   always_ff @(posedge clk) begin
      for (int i = 0; i < lpss_pkg::PIXEL_COUNT; i++) begin
         if (!reset_n) begin
            held[i] <= lpss_pkg::LEVEL_RESET;
         end else if (rise && lnk.data_latch) begin
            held[i] <= integ[i];
         end
      end
   end

   // ----------------------------------------------------------------
   // Pixel output, registered and stable for the whole clock period
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         lnk.analog_pixel_out    <= lpss_pkg::LEVEL_RESET;
         lnk.analog_pixel_out_oe <= 1'b0;
         readout_index           <= lpss_pkg::COUNT_RESET;
      end else if (scan_hit) begin
         lnk.analog_pixel_out_oe <= 1'b1;
         readout_index           <= lpss_pkg::COUNT_RESET;
         // With the latch tied to scan start, pixel 0 is the fresh capture
         if (lnk.data_latch) begin
            lnk.analog_pixel_out <= integ[0];
         end else begin
            lnk.analog_pixel_out <= held[0];
         end
      end else if (rise && phase != LPSS_IDLE) begin
         if (next_count == lpss_pkg::PIXELS) begin
            lnk.analog_pixel_out_oe <= 1'b0;
            lnk.analog_pixel_out    <= lpss_pkg::LEVEL_RESET;
         end else begin
            lnk.analog_pixel_out <= held[next_count];
            readout_index        <= next_count;
         end
      end
   end

   assign readout_active = lnk.analog_pixel_out_oe;

   // ----------------------------------------------------------------
   // Sampling stages: count of pixels tracking their integrators
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         sample_select_switch <= lpss_pkg::PIXELS;
      end else if (scan_hit) begin
         sample_select_switch <= lpss_pkg::COUNT_RESET;
      end else if (rise && phase != LPSS_IDLE &&
                   next_count >= lpss_pkg::SETUP_CLKS) begin
         // 18 at the 19th clock, then one more per clock up to n
         sample_select_switch <= next_count;
      end
   end

endmodule : lpss_sensor

// file: logic/lpss_host.sv
/*
 Host end of the linear pixel scan sequencer: divides clk into the pixel
 clock, issues the joint scan start and latch pulse, samples each pixel
 and enforces the charge transfer wait; a late scan request only sets period_overrun.
 Assumes the sensor end shares clk and updates its output within two
 clk cycles of a pixel clock rising edge.
*/
`timescale 1ns/1ps
module lpss_host #(
   parameter int XFER_CYCLES = lpss_pkg::XFER_CYCLES_I,
   parameter int MAX_PERIOD  = lpss_pkg::MAX_PERIOD_I
) (
   input  wire logic                   clk,
   input  wire logic                   reset_n,
   lpss_link_if.host                   lnk,
   input  wire logic                   scan_req,
   output logic                        scan_ready,
   output logic [11:0]                 pixel_data,
   output logic [9:0]                  pixel_index,
   output logic                        pixel_valid,
   output logic                        period_overrun
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      LPSS_H_IDLE  = 4'b0001,
      LPSS_H_SCAN  = 4'b0010,
      LPSS_H_CLOCK = 4'b0100,
      LPSS_H_XFER  = 4'b1000
   } lpss_host_state_type;

   lpss_host_state_type state;
   logic [4:0]          phase_cnt;
   logic                half_done;
   logic [9:0]          rise_cnt;
   logic [31:0]         wait_cnt;
   logic [31:0]         period_cnt;
   logic                primed;

   assign half_done  = (phase_cnt == lpss_pkg::HALF_CYCLES - 5'h01);
   assign scan_ready = (state == LPSS_H_IDLE);

   // ----------------------------------------------------------------
   // Sequencer and pixel clock divider
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state         <= LPSS_H_IDLE;
         phase_cnt     <= lpss_pkg::PHASE_RESET;
         rise_cnt      <= lpss_pkg::COUNT_RESET;
         wait_cnt      <= 32'h0;
         lnk.pixel_clk <= 1'b0;
      end else begin
         case (state)
            LPSS_H_IDLE: begin
               lnk.pixel_clk <= 1'b0;
               phase_cnt     <= lpss_pkg::PHASE_RESET;
               if (scan_req) begin
                  state <= LPSS_H_SCAN;
               end
            end
            LPSS_H_SCAN: begin
               phase_cnt <= phase_cnt + 5'h01;
               if (half_done) begin
                  lnk.pixel_clk <= 1'b1;
                  phase_cnt     <= lpss_pkg::PHASE_RESET;
                  rise_cnt      <= lpss_pkg::COUNT_RESET;
                  state         <= LPSS_H_CLOCK;
               end
            end
            LPSS_H_CLOCK: begin
               phase_cnt <= phase_cnt + 5'h01;
               if (half_done) begin
                  phase_cnt     <= lpss_pkg::PHASE_RESET;
                  lnk.pixel_clk <= ~lnk.pixel_clk;
                  if (lnk.pixel_clk && rise_cnt == lpss_pkg::PIXELS) begin
                     state    <= LPSS_H_XFER;
                     wait_cnt <= 32'h0;
                  end
                  if (!lnk.pixel_clk) begin
                     rise_cnt <= rise_cnt + 10'h001;
                  end
               end
            end
            LPSS_H_XFER: begin
               lnk.pixel_clk <= 1'b0;
               wait_cnt      <= wait_cnt + 32'h1;
               if (wait_cnt == 32'(XFER_CYCLES - 1)) begin
                  state <= LPSS_H_IDLE;
               end
            end
            default: begin
               state <= LPSS_H_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Joint scan start and latch pulse, high across one rising edge
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         lnk.scan_start <= 1'b0;
         lnk.data_latch <= 1'b0;
      end else begin
         lnk.scan_start <= (state == LPSS_H_SCAN);
         lnk.data_latch <= (state == LPSS_H_SCAN);
      end
   end

   // ----------------------------------------------------------------
   // Frame period watch
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         period_cnt     <= 32'h0;
         period_overrun <= 1'b0;
      end else if (state == LPSS_H_IDLE && scan_req) begin
         period_cnt     <= 32'h0;
         period_overrun <= (period_cnt >= 32'(MAX_PERIOD));
      end else if (period_cnt != 32'hFFFFFFFF) begin
         period_cnt <= period_cnt + 32'h1;
      end
   end

   // ----------------------------------------------------------------
   // Pixel sampling at each falling pixel clock edge while the output is enabled
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         primed      <= 1'b0;
         pixel_data  <= lpss_pkg::LEVEL_RESET;
         pixel_index <= lpss_pkg::COUNT_RESET;
         pixel_valid <= 1'b0;
      end else begin
         pixel_valid <= 1'b0;
         if (state == LPSS_H_XFER) begin
            primed <= 1'b1;
         end
         if (state == LPSS_H_CLOCK && half_done && lnk.pixel_clk &&
             lnk.analog_pixel_out_oe) begin
            pixel_data  <= lnk.analog_pixel_out;
            pixel_index <= rise_cnt;
            pixel_valid <= primed;
         end
      end
   end

endmodule : lpss_host

// file: tb/lpss_assertions.sv
/*
 Concurrent checks on the link between host and sensor ends: scan pulse
 shape, output enable window, output stability and pixel clock halves.
 Assumes it is instantiated beside the link interface in tb, on clk.
*/
`timescale 1ns/1ps
module lpss_assertions (
   input wire logic        clk,
   input wire logic        reset_n,
   input wire logic        pixel_clk,
   input wire logic        scan_start,
   input wire logic        data_latch,
   input wire logic [11:0] analog_pixel_out,
   input wire logic        analog_pixel_out_oe
);
   // ----------------------------------------------------------------
   // Pixel clock rise detection and rise numbering
   // ----------------------------------------------------------------
   logic       pclk_q;
   logic [9:0] rise_num;
   logic       rise;

   assign rise = pixel_clk & ~pclk_q;

   always_ff @(posedge clk) begin
      if (!reset_n)
         pclk_q <= 1'b0;
      else
         pclk_q <= pixel_clk;
   end

   // Number the next rise will carry; parks after the last one
   always_ff @(posedge clk) begin
      if (!reset_n)
         rise_num <= 10'h000;
      else if (rise && scan_start)
         rise_num <= 10'h001;
      else if (rise && rise_num != 10'h000 && rise_num != 10'h301)
         rise_num <= rise_num + 10'h001;
   end

   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   sequence s_scan_rise;
      rise && scan_start;
   endsequence
   sequence s_last_rise;
      rise && !scan_start && rise_num == 10'h300;
   endsequence
   sequence s_floating;
      !analog_pixel_out_oe ##0 analog_pixel_out == 12'h000;
   endsequence

   property p_scan_shows;
      s_scan_rise |=> analog_pixel_out_oe;
   endproperty
   property p_scan_once;
      s_scan_rise |=> !scan_start;
   endproperty
   property p_latch_tied;
      scan_start == data_latch;
   endproperty
   property p_last_float;
      s_last_rise |=> s_floating;
   endproperty
   property p_oe_holds;
      rise && analog_pixel_out_oe && rise_num < 10'h300
         |=> analog_pixel_out_oe;
   endproperty
   property p_idle_float;
      !analog_pixel_out_oe && !(rise && scan_start) |=> s_floating;
   endproperty
   property p_hold_stable;
      !rise |=> $stable(analog_pixel_out);
   endproperty
   property p_clk_high;
      $fell(pixel_clk) |-> $past(pixel_clk, 16);
   endproperty
   property p_clk_low;
      $rose(pixel_clk) |-> !$past(pixel_clk, 16);
   endproperty

   a_scan_shows : assert property (p_scan_shows)
      else $error("Output not enabled after scan start");
   a_scan_once : assert property (p_scan_once)
      else $error("Scan start high past one rising clock");
   a_latch_tied : assert property (p_latch_tied)
      else $error("Scan start and latch differ");
   a_last_float : assert property (p_last_float)
      else $error("Output not floating after last clock");
   a_oe_holds : assert property (p_oe_holds)
      else $error("Output dropped during readout");
   a_idle_float : assert property (p_idle_float)
      else $error("Output driven while idle");
   a_hold_stable : assert property (p_hold_stable)
      else $error("Output changed within a pixel period");
   a_clk_high : assert property (p_clk_high)
      else $error("Pixel clock high phase too short");
   a_clk_low : assert property (p_clk_low)
      else $error("Pixel clock low phase too short");
endmodule : lpss_assertions

// file: tb/tb.sv
/*
 Self-checking bench joining host and sensor ends through the link, with
 a behavioural light, integrator and readout model compared at each step.
 Assumes the design files and lpss_pkg are compiled before this file.
*/
`timescale 1ns/1ps
module tb;
   localparam int XFER  = 20;
   localparam int MAXP  = 30000;
   localparam int LIMIT = 100000;
   localparam int N     = lpss_pkg::PIXEL_COUNT;

   logic        clk                     = 1'b0;
   logic        reset_n                 = 1'b0;
   logic        scan_req                = 1'b0;
   logic        light_valid             = 1'b0;
   logic [9:0]  light_index             = 10'h000;
   logic [11:0] light_level             = 12'h000;
   logic        integrator_reset_switch;
   logic [9:0]  sample_select_switch;
   logic [9:0]  readout_index;
   logic        readout_active;
   logic        scan_ready;
   logic [11:0] pixel_data;
   logic [9:0]  pixel_index;
   logic        pixel_valid;
   logic        period_overrun;
   logic        pclk_q                  = 1'b0;
   logic        oe_q                    = 1'b0;
   int          fail_count              = 0;
   int          comparisons             = 0;
   int          cycles                  = 0;
   int          integ [N];
   int          hold_q [$];
   int          m_sel                   = N;
   int          m_k, m_idx, m_act, m_rst, chk, scans, gap, pv_cnt, s;

   always #2 clk = ~clk;

   lpss_link_if lnk ();

   lpss_sensor i_lpss_sensor (
      .clk(clk), .reset_n(reset_n), .lnk(lnk),
      .light_valid(light_valid), .light_index(light_index),
      .light_level(light_level),
      .integrator_reset_switch(integrator_reset_switch),
      .sample_select_switch(sample_select_switch),
      .readout_index(readout_index), .readout_active(readout_active));

   lpss_host #(.XFER_CYCLES(XFER), .MAX_PERIOD(MAXP)) i_lpss_host (
      .clk(clk), .reset_n(reset_n), .lnk(lnk), .scan_req(scan_req),
      .scan_ready(scan_ready), .pixel_data(pixel_data),
      .pixel_index(pixel_index), .pixel_valid(pixel_valid),
      .period_overrun(period_overrun));

   lpss_assertions i_lpss_assertions (
      .clk(clk), .reset_n(reset_n), .pixel_clk(lnk.pixel_clk),
      .scan_start(lnk.scan_start), .data_latch(lnk.data_latch),
      .analog_pixel_out(lnk.analog_pixel_out),
      .analog_pixel_out_oe(lnk.analog_pixel_out_oe));

   // ----------------------------------------------------------------
   // Comparison, closing report and scan tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask : check

   task automatic summarize;
      $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : summarize

   task automatic start_scan;
      @(posedge clk);
      scan_req <= 1'b1;
      @(posedge clk);
      scan_req <= 1'b0;
   endtask : start_scan

   task automatic wait_ready;
      do begin
         @(posedge clk);
         #1;
      end while (scan_ready !== 1'b1);
   endtask : wait_ready

   // ----------------------------------------------------------------
   // Light only in the cycle after a pixel clock high cycle, never in a rise cycle
   // ----------------------------------------------------------------
   always @(posedge clk) begin
      light_valid <= reset_n && lnk.pixel_clk && ($urandom_range(0, 1) == 0);
      light_index <= 10'($urandom_range(0, N - 1));
      light_level <= 12'($urandom_range(0, 1023));
   end

   // ----------------------------------------------------------------
   // Reference model and monitor
   // ----------------------------------------------------------------
   always @(posedge clk) begin
      if (reset_n === 1'b1) begin
         if (chk) begin
            check(32'(integrator_reset_switch), m_rst);
            check(32'(sample_select_switch), m_sel);
            check(32'(lnk.analog_pixel_out_oe), m_act);
            check(32'(readout_active), m_act);
            if (m_act) check(32'(readout_index), m_idx);
         end
         chk = 0;
         if (scan_ready === 1'b1) check(32'(lnk.pixel_clk), 0);
         if (light_valid === 1'b1 && !m_rst) begin
            s = integ[light_index] + int'(light_level);
            integ[light_index] = (s > 4095) ? 4095 : s;
         end
         if (lnk.pixel_clk === 1'b1 && pclk_q === 1'b0) begin
            chk = 1;
            if (lnk.scan_start === 1'b1) begin
               check(32'(m_act), 0);
               if (scans > 0) check(32'(gap >= XFER), 1);
               for (int i = 0; i < N; i++) begin
                  if (scans > 0) hold_q.push_back(integ[i]);
                  integ[i] = 0;
               end
               scans++;
               m_act = 1;
               m_rst = 1;
               m_k = 0;
               m_sel = 0;
               m_idx = 0;
            end else if (m_act) begin
               m_k++;
               if (m_k == 18) m_rst = 0;
               if (m_k >= 18) m_sel = m_k;
               if (m_k < N) m_idx = m_k;
               else m_act = 0;
            end
         end
         if (pixel_valid === 1'b1) begin
            pv_cnt++;
            s = N - hold_q.size();
            check(32'(pixel_index), s);
            s = hold_q.size() ? hold_q.pop_front() : -1;
            check(32'(pixel_data), s);
         end
         gap = (oe_q && !lnk.analog_pixel_out_oe) ? 0 : gap + 1;
      end
      pclk_q <= lnk.pixel_clk;
      oe_q <= lnk.analog_pixel_out_oe;
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         fail_count++;
         summarize();
      end
   end

   // ----------------------------------------------------------------
   // Main sequence: discard scan, normal scan, late scan
   // ----------------------------------------------------------------
   initial begin
      void'($urandom(32'hCEAD40E5));
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      for (int f = 0; f < 3; f++) begin
         if (f == 2) repeat (8000) @(posedge clk);
         pv_cnt = 0;
         start_scan();
         wait_ready();
         check(pv_cnt, (f == 0) ? 0 : N);
         check(hold_q.size(), 0);
         check(32'(period_overrun), f == 2);
      end
      summarize();
   end
endmodule : tb
